// *** rtl/abb_address_buffer_bridge.sv ***
`timescale 1ns/1ps
`include "abb_cfg.svh"
// Operation
// - In a processor cycle, processor address bits 2..19 go out on the system and peripheral address buses.
// - In a processor cycle, processor address bits 17..23 go out on the system upper address lines.
// - In a processor memory cycle that hits ROM space, the ROM select is asserted.
// - In a processor I/O cycle that hits the on-board port address, the port select is asserted.
// - In a DMA cycle, system upper address lines 17..23 are driven back onto processor bits 17..23.
// - In a DMA cycle, system address bits 2..16 are driven back onto processor bits 2..16.
// - In a DMA cycle while refresh enable is low, the refresh counter value is driven on system address bits 0..9.
// - The refresh counter steps by one after each finished refresh cycle.
// - The refresh counter is 10 bits wide, covering 256K and 1M DRAM refresh.
// - On a byte strobe falling edge, peripheral address bits 0..7 pass to system address bits 0..7.
// - On a byte strobe falling edge, peripheral data 7..0 is latched and driven on system address 15..8.
// - On a word strobe falling edge, peripheral address bits 0..8 pass to system address bits 0..8.
// - On a word strobe falling edge, peripheral data 7..0 is latched and driven on system address 16..9.
// - A timer produces the 8 MHz expansion bus timing.
// - While slow-down is low, processor progress is gated to the 8 MHz bus timing.
module abb_address_buffer_bridge (
  input  wire logic                              clk,                   // 200 MHz clock
  input  wire logic                              srst,                  // Sync reset, active high
  input  wire logic                              cpuCycle,              // 1 processor cycle, 0 DMA cycle
  input  wire logic                              cpuIoCycle,            // Processor cycle is an I/O cycle
  input  wire logic [`ABB_CPU_HI:`ABB_CPU_LO]    cpuAddrIn,             // Processor address pins, input
  output logic      [`ABB_CPU_HI:`ABB_CPU_LO]    cpuAddrOut,            // Processor address pins, output
  output logic                                   cpuAddrOeN,            // Processor address drive, low drives
  input  wire logic [`ABB_SYS_HI:0]              systemAddrIn,          // System address pins, input
  output logic      [`ABB_SYS_HI:0]              systemAddrOut,         // System address pins, output
  output logic      [`ABB_SYS_HI:0]              systemAddrOeN,         // Per-bit drive, low drives
  input  wire logic [`ABB_CPU_HI:`ABB_UPPER_LO]  systemUpperAddrIn,     // Upper system address, input
  output logic      [`ABB_CPU_HI:`ABB_UPPER_LO]  systemUpperAddrOut,    // Upper system address, output
  output logic                                   systemUpperAddrOeN,    // Upper drive, low drives
  input  wire logic [`ABB_PER_W-1:0]             peripheralAddrIn,      // Peripheral address pins, input
  output logic      [`ABB_PER_W-1:0]             peripheralAddrOut,     // Peripheral address pins, output
  output logic                                   peripheralAddrOeN,     // Peripheral drive, low drives
  input  wire logic [7:0]                        peripheralData,        // Peripheral data low byte
  input  wire logic                              refreshEnableN,        // Refresh cycle, active low
  input  wire logic                              byteDmaAddrStrobeN,    // 8-bit DMA address strobe
  input  wire logic                              wordDmaAddrStrobeN,    // 16-bit DMA address strobe
  input  wire logic                              slowDownN,             // Slow to AT timing, active low
  output logic                                   romSelectN,            // ROM select, active low
  output logic                                   ioPortSelectN,         // On-board port select, active low
  output logic                                   busTick,               // 8 MHz bus timing pulse
  output logic                                   cpuClkEn               // Processor advance enable
);
  import abb_pkg::*;

  abb_state_s state;
  abb_state_s next_state;
  logic       byteFall;
  logic       wordFall;
  logic       romHit;
  logic       ioHit;

  assign byteFall = state.byteStbQ & ~byteDmaAddrStrobeN;
  assign wordFall = state.wordStbQ & ~wordDmaAddrStrobeN;
  assign romHit   = (cpuAddrIn[`ABB_SYS_HI:`ABB_UPPER_LO] == `ABB_ROM_LOW_TAG
                     && cpuAddrIn[`ABB_CPU_HI:`ABB_SYS_HI+1] == `ABB_ROM_LOW_HIGH)
                    || cpuAddrIn[`ABB_CPU_HI:`ABB_UPPER_LO] == `ABB_ROM_HIGH_TAG;
  assign ioHit    = cpuAddrIn[`ABB_IO_HI:`ABB_CPU_LO] == `ABB_IO_BASE;

  always_comb
  begin
    next_state          = state;
    next_state.byteStbQ = byteDmaAddrStrobeN;
    next_state.wordStbQ = wordDmaAddrStrobeN;

    // 200/8 is whole; ticks land every 25 cycles, exactly 8 MHz
    if (state.tickCount == `ABB_TICK_LAST)
    begin
      next_state.tickCount = '0;
      next_state.busTick   = 1'b1;
    end
    else
    begin
      next_state.tickCount = state.tickCount + 1'b1;
      next_state.busTick   = 1'b0;
    end
    next_state.cpuClkEn = slowDownN | (state.tickCount == `ABB_TICK_LAST);

    case (state.rfState)
      ABB_RF_IDLE:
      begin
        if (!refreshEnableN)
          next_state.rfState = ABB_RF_ACTIVE;
      end
      ABB_RF_ACTIVE:
      begin
        if (refreshEnableN)
        begin
          next_state.rfState      = ABB_RF_IDLE;
          next_state.refreshCount = state.refreshCount + `ABB_REF_STEP;
        end
      end
      default:
      begin
        next_state.rfState = ABB_RF_IDLE;
      end
    endcase

    // Strobe edges are taken in any cycle so the latch follows the DMA controller
    if (wordFall)
    begin
      next_state.upperLatch = peripheralData;
      next_state.latchWord  = 1'b1;
      next_state.latchValid = 1'b1;
    end
    else if (byteFall)
    begin
      next_state.upperLatch = peripheralData;
      next_state.latchWord  = 1'b0;
      next_state.latchValid = 1'b1;
    end

    next_state.cpuAddrOeN    = 1'b1;
    next_state.sysAddrOeN    = '1;
    next_state.sysUpperOeN   = 1'b1;
    next_state.periphAddrOeN = 1'b1;
    next_state.romSelectN    = 1'b1;
    next_state.ioPortSelectN = 1'b1;

    if (cpuCycle)
    begin
      next_state.sysAddrOut[`ABB_SYS_HI:`ABB_CPU_LO]    = cpuAddrIn[`ABB_SYS_HI:`ABB_CPU_LO];
      next_state.sysAddrOeN[`ABB_SYS_HI:`ABB_CPU_LO]    = '0;
      next_state.periphAddrOut[`ABB_SYS_HI:`ABB_CPU_LO] = cpuAddrIn[`ABB_SYS_HI:`ABB_CPU_LO];
      next_state.periphAddrOeN = 1'b0;
      next_state.sysUpperOut   = cpuAddrIn[`ABB_CPU_HI:`ABB_UPPER_LO];
      next_state.sysUpperOeN   = 1'b0;
      next_state.romSelectN    = ~(romHit & ~cpuIoCycle);
      next_state.ioPortSelectN = ~(ioHit & cpuIoCycle);
    end
    else
    begin
      // Upper lines win on the overlapping bits 17..19
      next_state.cpuAddrOut[`ABB_UPPER_LO-1:`ABB_CPU_LO] = systemAddrIn[`ABB_UPPER_LO-1:`ABB_CPU_LO];
      next_state.cpuAddrOut[`ABB_CPU_HI:`ABB_UPPER_LO]   = systemUpperAddrIn;
      next_state.cpuAddrOeN = 1'b0;
      if (!refreshEnableN)
      begin
        next_state.sysAddrOut[`ABB_REF_W-1:0] = state.refreshCount;
        next_state.sysAddrOeN[`ABB_REF_W-1:0] = '0;
      end
      else if (next_state.latchValid && next_state.latchWord)
      begin
        next_state.sysAddrOut[`ABB_WORD_TOP:0] = peripheralAddrIn[`ABB_WORD_TOP:0];
        next_state.sysAddrOut[`ABB_WORD_UP_HI:`ABB_WORD_TOP+1] = next_state.upperLatch;
        next_state.sysAddrOeN[`ABB_WORD_UP_HI:0] = '0;
      end
      else if (next_state.latchValid)
      begin
        next_state.sysAddrOut[`ABB_BYTE_TOP:0] = peripheralAddrIn[`ABB_BYTE_TOP:0];
        next_state.sysAddrOut[`ABB_BYTE_UP_HI:`ABB_BYTE_TOP+1] = next_state.upperLatch;
        next_state.sysAddrOeN[`ABB_BYTE_UP_HI:0] = '0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state              <= '0;
      state.rfState      <= ABB_RF_IDLE;
      state.refreshCount <= `ABB_REF_RESET;
      state.byteStbQ     <= 1'b1;
      state.wordStbQ     <= 1'b1;
      state.cpuClkEn     <= 1'b1;
      state.cpuAddrOeN   <= 1'b1;
      state.sysAddrOeN   <= '1;
      state.sysUpperOeN  <= 1'b1;
      state.periphAddrOeN <= 1'b1;
      state.romSelectN   <= 1'b1;
      state.ioPortSelectN <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign cpuAddrOut         = state.cpuAddrOut;
  assign cpuAddrOeN         = state.cpuAddrOeN;
  assign systemAddrOut      = state.sysAddrOut;
  assign systemAddrOeN      = state.sysAddrOeN;
  assign systemUpperAddrOut = state.sysUpperOut;
  assign systemUpperAddrOeN = state.sysUpperOeN;
  assign peripheralAddrOut  = state.periphAddrOut;
  assign peripheralAddrOeN  = state.periphAddrOeN;
  assign romSelectN         = state.romSelectN;
  assign ioPortSelectN      = state.ioPortSelectN;
  assign busTick            = state.busTick;
  assign cpuClkEn           = state.cpuClkEn;

  a_cpu_low_out: assert property (@(posedge clk) disable iff (srst)
    cpuCycle |=> systemAddrOut[19:2] == $past(cpuAddrIn[19:2]) && peripheralAddrOut[19:2] == systemAddrOut[19:2]
                 && systemAddrOeN[19:2] == '0 && !peripheralAddrOeN)
    else $error("processor address not forwarded");
  a_cpu_upper_out: assert property (@(posedge clk) disable iff (srst)
    cpuCycle |=> systemUpperAddrOut == $past(cpuAddrIn[23:17]) && !systemUpperAddrOeN && cpuAddrOeN)
    else $error("upper address not forwarded");
  a_rom_select: assert property (@(posedge clk) disable iff (srst)
    cpuCycle && !cpuIoCycle
      |=> romSelectN == !($past(cpuAddrIn[23:17]) == 7'h07 || $past(cpuAddrIn[23:17]) == 7'h7f))
    else $error("ROM select wrong");
  a_io_select: assert property (@(posedge clk) disable iff (srst)
    cpuCycle && cpuIoCycle |=> ioPortSelectN == ($past(cpuAddrIn[15:2]) != 14'h0000) && romSelectN)
    else $error("I/O port select wrong");
  a_dma_upper_back: assert property (@(posedge clk) disable iff (srst)
    !cpuCycle |=> cpuAddrOut[23:17] == $past(systemUpperAddrIn) && !cpuAddrOeN)
    else $error("upper address not returned in DMA");
  a_dma_low_back: assert property (@(posedge clk) disable iff (srst)
    !cpuCycle |=> cpuAddrOut[16:2] == $past(systemAddrIn[16:2]))
    else $error("low address not returned in DMA");
  a_refresh_drive: assert property (@(posedge clk) disable iff (srst)
    !cpuCycle && !refreshEnableN |=> systemAddrOut[9:0] == $past(state.refreshCount) && systemAddrOeN[9:0] == '0)
    else $error("refresh address not driven");
  a_refresh_step: assert property (@(posedge clk) disable iff (srst)
    state.rfState == ABB_RF_ACTIVE && refreshEnableN
      |=> state.refreshCount == $past(state.refreshCount) + `ABB_REF_STEP)
    else $error("refresh counter did not step");
  a_byte_latch: assert property (@(posedge clk) disable iff (srst)
    byteFall && !wordFall && !cpuCycle && refreshEnableN
      |=> systemAddrOut[15:8] == $past(peripheralData) && systemAddrOut[7:0] == $past(peripheralAddrIn[7:0]))
    else $error("byte DMA address wrong");
  a_word_latch: assert property (@(posedge clk) disable iff (srst)
    wordFall && !cpuCycle && refreshEnableN
      |=> systemAddrOut[16:9] == $past(peripheralData) && systemAddrOut[8:0] == $past(peripheralAddrIn[8:0]))
    else $error("word DMA address wrong");
  a_latch_hold: assert property (@(posedge clk) disable iff (srst)
    !byteFall && !wordFall |=> $stable(state.upperLatch))
    else $error("latched upper address changed");
  a_bus_tick_period: assert property (@(posedge clk) disable iff (srst)
    busTick |=> !busTick [*8] ##1 !busTick [*8] ##1 !busTick [*8] ##1 busTick)
    else $error("bus tick period wrong");
  a_slow_gate: assert property (@(posedge clk) disable iff (srst)
    $past(!slowDownN) && cpuClkEn |-> busTick)
    else $error("processor not slowed");

endmodule

// *** shared/abb_cfg.svh ***
`ifndef ABB_CFG_SVH
`define ABB_CFG_SVH

// Clock rates in MHz
`define ABB_CLK_MHZ        200
`define ABB_BUS_MHZ        8
`define ABB_TICK_W         5
`define ABB_TICK_LAST      5'((`ABB_CLK_MHZ + `ABB_BUS_MHZ - 1) / `ABB_BUS_MHZ - 1)

// Refresh counter
`define ABB_REF_W          10
`define ABB_REF_RESET      10'h000
`define ABB_REF_STEP       10'h001

// Address fields
`define ABB_CPU_HI         23
`define ABB_CPU_LO         2
`define ABB_SYS_HI         19
`define ABB_UPPER_LO       17
`define ABB_PER_W          20

// ROM space: 0e0000-0fffff and fe0000-ffffff images of the top 128K
`define ABB_ROM_LOW_TAG    3'h7
`define ABB_ROM_LOW_HIGH   4'h0
`define ABB_ROM_HIGH_TAG   7'h7f

// On-board I/O port, word address bits 15:2
`define ABB_IO_HI          15
`define ABB_IO_BASE        14'h0000

// DMA address split: low bits from the peripheral bus, latched byte above
`define ABB_BYTE_TOP       7
`define ABB_BYTE_UP_HI     15
`define ABB_WORD_TOP       8
`define ABB_WORD_UP_HI     16

`endif

// *** shared/abb_pkg.sv ***
`include "abb_cfg.svh"
package abb_pkg;

  typedef enum logic [1:0] {
    ABB_RF_IDLE   = 2'b01,
    ABB_RF_ACTIVE = 2'b10
  } abb_refresh_e;

  typedef struct packed {
    abb_refresh_e                      rfState;
    logic [`ABB_REF_W-1:0]             refreshCount;
    logic                              byteStbQ;
    logic                              wordStbQ;
    logic [7:0]                        upperLatch;
    logic                              latchWord;
    logic                              latchValid;
    logic [`ABB_TICK_W-1:0]            tickCount;
    logic                              busTick;
    logic                              cpuClkEn;
    logic [`ABB_CPU_HI:`ABB_CPU_LO]    cpuAddrOut;
    logic                              cpuAddrOeN;
    logic [`ABB_SYS_HI:0]              sysAddrOut;
    logic [`ABB_SYS_HI:0]              sysAddrOeN;
    logic [`ABB_CPU_HI:`ABB_UPPER_LO]  sysUpperOut;
    logic                              sysUpperOeN;
    logic [`ABB_PER_W-1:0]             periphAddrOut;
    logic                              periphAddrOeN;
    logic                              romSelectN;
    logic                              ioPortSelectN;
  } abb_state_s;

endpackage

// *** verification/abb_address_buffer_bridge_test.sv ***
`timescale 1ns/1ps
`include "abb_cfg.svh"
module abb_address_buffer_bridge_test;
  logic clk = 1'b0, srst = 1'b1, cpuCycle = 1'b1, cpuIoCycle = 1'b0, refN = 1'b1;
  logic byteN = 1'b1, wordN = 1'b1, slowN = 1'b1;
  logic [23:0] cpuDrv = 24'h000000;
  logic [19:0] perDrv = 20'h00000, dmaAddr = 20'h00000;
  logic [6:0]  dmaUpper = 7'h00;
  logic [7:0]  perData = 8'h00;
  logic [23:2] cpuIn, cpuOut;
  logic [19:0] sysIn, sysOut, sysOeN, perIn, perOut;
  logic [23:17] upIn, upOut;
  logic cpuOeN, upOeN, perOeN, romN, ioN, busTick, cpuClkEn;
  int mismatches = 0, cmpCount = 0, cycles = 0;
  always #2.5 clk = ~clk;
  assign cpuIn = cpuOeN ? cpuDrv[23:2] : cpuOut;
  assign perIn = perOeN ? perDrv : perOut;
  abb_dma_partner partner_u (.clk(clk), .dmaOwn(!cpuCycle), .dmaAddr(dmaAddr), .dmaUpper(dmaUpper),
    .devAddr(sysOut), .devAddrOeN(sysOeN), .devUpper(upOut), .devUpperOeN(upOeN),
    .sysAddr(sysIn), .sysUpper(upIn));
  abb_address_buffer_bridge dut_u (.clk(clk), .srst(srst), .cpuCycle(cpuCycle), .cpuIoCycle(cpuIoCycle),
    .cpuAddrIn(cpuIn), .cpuAddrOut(cpuOut), .cpuAddrOeN(cpuOeN), .systemAddrIn(sysIn),
    .systemAddrOut(sysOut), .systemAddrOeN(sysOeN), .systemUpperAddrIn(upIn),
    .systemUpperAddrOut(upOut), .systemUpperAddrOeN(upOeN), .peripheralAddrIn(perIn),
    .peripheralAddrOut(perOut), .peripheralAddrOeN(perOeN), .peripheralData(perData),
    .refreshEnableN(refN), .byteDmaAddrStrobeN(byteN), .wordDmaAddrStrobeN(wordN), .slowDownN(slowN),
    .romSelectN(romN), .ioPortSelectN(ioN), .busTick(busTick), .cpuClkEn(cpuClkEn));
  task automatic tally_and_finish();
    if (mismatches == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard well above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cpu_path_test();
    logic [26:0] dec [6] = '{{3'b001, 24'h0e0000}, {3'b001, 24'h0ffffc}, {3'b001, 24'hfe0000},
                             {3'b011, 24'h100000}, {3'b110, 24'h000000}, {3'b111, 24'h000004}};
    cpuCycle = 1'b1;
    cpuDrv = 24'ha5678c;
    cyc(2);
    check("sys addr", {14'h0, cpuDrv[19:2]}, {14'h0, sysOut[19:2]});
    check("per addr", {14'h0, cpuDrv[19:2]}, {14'h0, perOut[19:2]});
    check("drive enables", 32'h0, {12'h0, sysOeN[19:2], perOeN, upOeN});
    check("upper addr", {25'h0, cpuDrv[23:17]}, {25'h0, upOut});
    foreach (dec[i])
    begin
      cpuIoCycle = dec[i][26];
      cpuDrv = dec[i][23:0];
      cyc(2);
      check("rom select", {31'h0, dec[i][25]}, {31'h0, romN});
      check("io select", {31'h0, dec[i][24]}, {31'h0, ioN});
    end
    cpuIoCycle = 1'b0;
  endtask
  task automatic dma_path_test();
    cpuCycle = 1'b0;
    dmaAddr = 20'h5a3c4;
    dmaUpper = 7'h2b;
    cyc(2);
    check("cpu upper", 32'h2b, {25'h0, cpuOut[23:17]});
    check("cpu low", {17'h0, dmaAddr[16:2]}, {17'h0, cpuOut[16:2]});
    check("cpu drive", 32'h0, {31'h0, cpuOeN});
    check("dma releases", 32'h3, {30'h0, upOeN, perOeN});
  endtask
  task automatic reset_test();
    // Mid-run reset in a DMA cycle: all drives off, latch forgotten, count restarts
    srst = 1'b1;
    cyc(2);
    check("reset state", 32'h7fffffe, {5'h0, sysOeN, cpuOeN, upOeN, perOeN, romN, ioN, cpuClkEn, busTick});
    srst = 1'b0;
    cyc(2);
    check("latch cleared", 32'hffff, {16'h0, sysOeN[15:0]});
    refN = 1'b0;
    cyc(2);
    check("refresh restart", 32'h0, {22'h0, sysOut[9:0]});
    refN = 1'b1;
    cyc(2);
  endtask
  task automatic refresh_test();
    // One lap past 1023 proves width and wrap
    for (int i = 0; i <= 1024; i++)
    begin
      refN = 1'b0;
      cyc(2);
      check("refresh addr", i % 1024, {22'h0, sysOut[9:0]});
      check("refresh drive", 32'h0, {22'h0, sysOeN[9:0]});
      refN = 1'b1;
      cyc(2);
    end
  endtask
  task automatic strobe_test();
    perDrv = 20'h0a5c3;
    perData = 8'h96;
    byteN = 1'b0;
    cyc(2);
    check("byte dma addr", 32'h96c3, {16'h0, sysOut[15:0]});
    check("byte dma drive", 32'h0, {16'h0, sysOeN[15:0]});
    byteN = 1'b1;
    perData = 8'h11;
    cyc(2);
    check("latch hold", 32'h96, {24'h0, sysOut[15:8]});
    perData = 8'h3e;
    wordN = 1'b0;
    cyc(2);
    check("word dma addr", {15'h0, 8'h3e, 9'h1c3}, {15'h0, sysOut[16:0]});
    wordN = 1'b1;
    cyc(1);
  endtask
  task automatic timer_test();
    int gap;
    int ticks;
    int bad;
    gap = 0;
    while (busTick !== 1'b1 && gap < 60)
    begin
      cyc(1);
      gap++;
    end
    gap = 0;
    do
    begin
      cyc(1);
      gap++;
    end while (busTick !== 1'b1 && gap < 60);
    check("tick gap", 32'd25, gap);
    slowN = 1'b0;
    cyc(3);
    ticks = 0;
    bad = 0;
    repeat (100)
    begin
      cyc(1);
      ticks += (busTick === 1'b1);
      bad += (cpuClkEn !== busTick);
    end
    check("ticks per 100", 32'd4, ticks);
    check("slow enable", 32'd0, bad);
    slowN = 1'b1;
    cyc(2);
    bad = 0;
    repeat (30)
    begin
      cyc(1);
      bad += (cpuClkEn !== 1'b1);
    end
    check("full speed", 32'd0, bad);
  endtask
  initial
  begin
    cyc(3);
    srst = 1'b0;
    cyc(1);
    cpu_path_test();
    dma_path_test();
    refresh_test();
    strobe_test();
    reset_test();
    timer_test();
    tally_and_finish();
  end
endmodule

// *** verification/abb_dma_partner.sv ***
`timescale 1ns/1ps
`include "abb_cfg.svh"
module abb_dma_partner (
  input  wire logic                             clk,         // Bus clock
  input  wire logic                             dmaOwn,      // Controller owns system bus
  input  wire logic [`ABB_SYS_HI:0]             dmaAddr,     // Controller address
  input  wire logic [`ABB_CPU_HI:`ABB_UPPER_LO] dmaUpper,    // Controller upper address
  input  wire logic [`ABB_SYS_HI:0]             devAddr,     // Device address drive
  input  wire logic [`ABB_SYS_HI:0]             devAddrOeN,  // Device enables, low drives
  input  wire logic [`ABB_CPU_HI:`ABB_UPPER_LO] devUpper,    // Device upper drive
  input  wire logic                             devUpperOeN, // Device upper enable
  output logic      [`ABB_SYS_HI:0]             sysAddr,     // Resolved address wire
  output logic      [`ABB_CPU_HI:`ABB_UPPER_LO] sysUpper     // Resolved upper wire
);
  logic [`ABB_SYS_HI:0]             lastAddr;
  logic [`ABB_CPU_HI:`ABB_UPPER_LO] lastUpper;
  // Bits released while the controller does not own the bus flip each cycle so a stale value never looks driven
  always_comb
  begin
    for (int i = 0; i <= `ABB_SYS_HI; i++)
      sysAddr[i] = !devAddrOeN[i] ? devAddr[i] : (dmaOwn ? dmaAddr[i] : ~lastAddr[i]);
    sysUpper = !devUpperOeN ? devUpper : (dmaOwn ? dmaUpper : ~lastUpper);
  end
  always_ff @(posedge clk)
  begin
    lastAddr  <= sysAddr;
    lastUpper <= sysUpper;
  end
endmodule
